// ### hw/spcs_port_regs.v
/*
 * Command and primary status register pair of one switch port, with the
 * gating that the command bits apply to the port's traffic, the sticky
 * status events, and an interrupt status/mask pair.
 * Assumes all request and event inputs come from port logic on mclk,
 * each event a one-cycle pulse, and a bus master that never waits.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spcs_regs.vh"

module spcs_port_regs (
    input  wire                      mclk,
    input  wire                      reset,
    input  wire                      ce,
    // register port
    input  wire [`SPCS_ADDR_W-1:0]   reg_addr,
    input  wire [`SPCS_DATA_W-1:0]   reg_wdata,
    input  wire                      reg_wr,
    input  wire                      reg_rd,
    output reg  [`SPCS_DATA_W-1:0]   reg_rdata_q,
    // primary side requests aimed at this port
    input  wire                      io_req,
    input  wire                      mem_req,
    output reg                       io_accept_q,
    output reg                       io_ignore_q,
    output reg                       mem_accept_q,
    output reg                       mem_ignore_q,
    // requests from downstream heading upstream
    input  wire                      up_req,
    input  wire                      up_req_posted,
    output reg                       up_forward_q,
    output reg                       up_reject_ur_q,
    output reg                       up_cpl_ur_q,
    // own requests originated by the port toward upstream
    input  wire                      own_req,
    output reg                       own_req_go_q,
    // parity and error reporting
    input  wire                      parity_err,
    output reg                       parity_action_q,
    input  wire                      err_msg_req,
    output reg                       system_error_report_line_q,
    // legacy interrupt messages
    input  wire                      intx_own_req,
    input  wire                      intx_fwd_in,
    output reg                       intx_own_q,
    output reg                       intx_fwd_q,
    // completion events
    input  wire                      cpl_ca_sent,
    input  wire                      cpl_ca_rcvd,
    input  wire                      cpl_ur_rcvd,
    input  wire                      poisoned_rcvd,
    // interrupt
    output reg                       irq_q
);

    // ------------------------------------------------------------------
    // address decode, shared by the write and the read path
    // ------------------------------------------------------------------
    function [`SPCS_SEL_W-1:0] decode_sel;
        input [`SPCS_ADDR_W-1:0] addr;
        begin
            case (addr)
                `SPCS_OFF_CMD_STS:  decode_sel = `SPCS_SEL_CMD_STS;
                `SPCS_OFF_INT_STS:  decode_sel = `SPCS_SEL_INT_STS;
                `SPCS_OFF_INT_MASK: decode_sel = `SPCS_SEL_INT_MASK;
                default:            decode_sel = `SPCS_SEL_NONE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // map the event vector onto the status half word
    // ------------------------------------------------------------------
    function [`SPCS_HALF_W-1:0] status_word;
        input [`SPCS_EV_N-1:0] ev;
        reg   [`SPCS_HALF_W-1:0] w;
        begin
            // legacy and reserved positions stay zero
            w = `SPCS_ZERO16;
            w[`SPCS_STS_INT_PEND] = `SPCS_STS_PEND_VAL;
            w[`SPCS_STS_CAP_LIST] = `SPCS_STS_CAP_VAL;
            w[`SPCS_STS_MDPE]     = ev[`SPCS_EV_MDPE];
            w[`SPCS_STS_STA]      = ev[`SPCS_EV_STA];
            w[`SPCS_STS_RTA]      = ev[`SPCS_EV_RTA];
            w[`SPCS_STS_RMA]      = ev[`SPCS_EV_RMA];
            w[`SPCS_STS_SSE]      = ev[`SPCS_EV_SSE];
            w[`SPCS_STS_DPE]      = ev[`SPCS_EV_DPE];
            status_word = w;
        end
    endfunction

    // ------------------------------------------------------------------
    // and the reverse: status half word positions to event vector
    // ------------------------------------------------------------------
    function [`SPCS_EV_N-1:0] status_to_ev;
        input [`SPCS_HALF_W-1:0] w;
        begin
            status_to_ev = `SPCS_EV_ZERO;
            status_to_ev[`SPCS_EV_MDPE] = w[`SPCS_STS_MDPE];
            status_to_ev[`SPCS_EV_STA]  = w[`SPCS_STS_STA];
            status_to_ev[`SPCS_EV_RTA]  = w[`SPCS_STS_RTA];
            status_to_ev[`SPCS_EV_RMA]  = w[`SPCS_STS_RMA];
            status_to_ev[`SPCS_EV_SSE]  = w[`SPCS_STS_SSE];
            status_to_ev[`SPCS_EV_DPE]  = w[`SPCS_STS_DPE];
        end
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    reg  [`SPCS_HALF_W-1:0]  cmd_q;
    reg  [`SPCS_HALF_W-1:0]  cmd_d;
    reg  [`SPCS_EV_N-1:0]    int_mask_q;
    wire [`SPCS_EV_N-1:0]    sts_flag;
    wire [`SPCS_EV_N-1:0]    int_flag;
    reg  [`SPCS_EV_N-1:0]    ev_set;
    wire [`SPCS_SEL_W-1:0]   wr_sel;
    wire [`SPCS_SEL_W-1:0]   rd_sel;
    wire [`SPCS_EV_N-1:0]    sts_clr;
    wire [`SPCS_EV_N-1:0]    int_clr;
    wire                     io_en;
    wire                     mem_en;
    wire                     bm_en;
    wire                     par_en;
    wire                     err_en;
    wire                     int_dis;
    reg  [`SPCS_DATA_W-1:0]  rd_word;

    assign wr_sel = decode_sel(reg_addr);
    assign rd_sel = decode_sel(reg_addr);

    // command fields that steer the port
    assign io_en   = cmd_q[`SPCS_CMD_IO_EN];
    assign mem_en  = cmd_q[`SPCS_CMD_MEM_EN];
    assign bm_en   = cmd_q[`SPCS_CMD_BM_EN];
    assign par_en  = cmd_q[`SPCS_CMD_PAR_RESP];
    assign err_en  = cmd_q[`SPCS_CMD_ERR_RPT];
    assign int_dis = cmd_q[`SPCS_CMD_INT_DIS];

    // ------------------------------------------------------------------
    // command register
    // ------------------------------------------------------------------
    // only the six documented control bits take write data; legacy and
    // reserved bits are masked out so they never hold a one
    always @* begin
        cmd_d = cmd_q;
        if (reg_wr && (wr_sel == `SPCS_SEL_CMD_STS)) begin
            cmd_d = reg_wdata[`SPCS_HALF_W-1:0] & `SPCS_CMD_WMASK;
        end
    end

    // every control bit comes out of reset at zero
    always @(posedge mclk) begin
        if (reset) begin
            cmd_q <= `SPCS_CMD_RESET;
        end else if (ce) begin
            cmd_q <= cmd_d;
        end
    end

    // ------------------------------------------------------------------
    // status events
    // ------------------------------------------------------------------
    // mdpe and sse are qualified by the command bits that govern them; sta, rta, rma and dpe set unqualified
    always @* begin
        ev_set = `SPCS_EV_ZERO;
        ev_set[`SPCS_EV_MDPE] = parity_err & par_en;
        ev_set[`SPCS_EV_STA]  = cpl_ca_sent;
        ev_set[`SPCS_EV_RTA]  = cpl_ca_rcvd;
        ev_set[`SPCS_EV_RMA]  = cpl_ur_rcvd;
        ev_set[`SPCS_EV_SSE]  = err_msg_req & err_en;
        ev_set[`SPCS_EV_DPE]  = poisoned_rcvd;
    end

    // status clears need a written one, and only on w1c positions
    assign sts_clr = (reg_wr && (wr_sel == `SPCS_SEL_CMD_STS)) ?
                     (status_to_ev(reg_wdata[`SPCS_DATA_W-1:`SPCS_HALF_W]) & `SPCS_EV_W1C) :
                     `SPCS_EV_ZERO;

    // interrupt status is write-one-to-clear on every bit
    assign int_clr = (reg_wr && (wr_sel == `SPCS_SEL_INT_STS)) ?
                     reg_wdata[`SPCS_EV_N-1:0] : `SPCS_EV_ZERO;

    // ------------------------------------------------------------------
    // sticky flags: pci status and interrupt status per event
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SPCS_EV_N; gi = gi + 1) begin : g_ev
            spcs_sticky_bit u_sts (
                .mclk   (mclk),
                .reset  (reset),
                .ce     (ce),
                .set    (ev_set[gi]),
                .clr    (sts_clr[gi]),
                .flag_q (sts_flag[gi])
            );
            spcs_sticky_bit u_int (
                .mclk   (mclk),
                .reset  (reset),
                .ce     (ce),
                .set    (ev_set[gi]),
                .clr    (int_clr[gi]),
                .flag_q (int_flag[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt mask and output
    // ------------------------------------------------------------------
    // a one in the mask lets that status bit drive the interrupt
    always @(posedge mclk) begin
        if (reset) begin
            int_mask_q <= `SPCS_EV_RESET;
        end else if (ce) begin
            if (reg_wr && (wr_sel == `SPCS_SEL_INT_MASK)) begin
                int_mask_q <= reg_wdata[`SPCS_EV_N-1:0];
            end
        end
    end

    // registered, so irq trails the flag by one cycle
    always @(posedge mclk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(int_flag & int_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // unmapped offsets read as zero; the slave never stalls
    always @* begin
        rd_word = `SPCS_ZERO32;
        case (rd_sel)
            `SPCS_SEL_CMD_STS: begin
                rd_word = {status_word(sts_flag), cmd_q};
            end
            `SPCS_SEL_INT_STS: begin
                rd_word[`SPCS_EV_N-1:0] = int_flag;
            end
            `SPCS_SEL_INT_MASK: begin
                rd_word[`SPCS_EV_N-1:0] = int_mask_q;
            end
            default: begin
                rd_word = `SPCS_ZERO32;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata_q <= `SPCS_ZERO32;
        end else if (ce) begin
            if (reg_rd) begin
                reg_rdata_q <= rd_word;
            end else begin
                reg_rdata_q <= `SPCS_ZERO32;
            end
        end
    end

    // ------------------------------------------------------------------
    // primary side request gating
    // ------------------------------------------------------------------
    // exactly one of accept/ignore pulses per incoming request
    always @(posedge mclk) begin
        if (reset) begin
            io_accept_q  <= 1'b0;
            io_ignore_q  <= 1'b0;
            mem_accept_q <= 1'b0;
            mem_ignore_q <= 1'b0;
        end else if (ce) begin
            io_accept_q  <= io_req & io_en;
            io_ignore_q  <= io_req & ~io_en;
            mem_accept_q <= mem_req & mem_en;
            mem_ignore_q <= mem_req & ~mem_en;
        end
    end

    // ------------------------------------------------------------------
    // upstream forwarding under bus master enable
    // ------------------------------------------------------------------
    // posted requests rejected as ur are dropped silently; only
    // non-posted ones earn a ur completion back downstream
    always @(posedge mclk) begin
        if (reset) begin
            up_forward_q   <= 1'b0;
            up_reject_ur_q <= 1'b0;
            up_cpl_ur_q    <= 1'b0;
            own_req_go_q   <= 1'b0;
        end else if (ce) begin
            up_forward_q   <= up_req & bm_en;
            up_reject_ur_q <= up_req & ~bm_en;
            up_cpl_ur_q    <= up_req & ~bm_en & ~up_req_posted;
            own_req_go_q   <= own_req & bm_en;
        end
    end

    // ------------------------------------------------------------------
    // parity action and error message reporting
    // ------------------------------------------------------------------
    // with parity response off the error is simply not acted on
    always @(posedge mclk) begin
        if (reset) begin
            parity_action_q            <= 1'b0;
            system_error_report_line_q <= 1'b0;
        end else if (ce) begin
            parity_action_q            <= parity_err & par_en;
            system_error_report_line_q <= err_msg_req & err_en;
        end
    end

    // ------------------------------------------------------------------
    // legacy interrupt messages
    // ------------------------------------------------------------------
    // forwarding ignores interrupt disable and never touches status
    always @(posedge mclk) begin
        if (reset) begin
            intx_own_q <= 1'b0;
            intx_fwd_q <= 1'b0;
        end else if (ce) begin
            intx_own_q <= intx_own_req & ~int_dis;
            intx_fwd_q <= intx_fwd_in;
        end
    end

endmodule // spcs_port_regs

`default_nettype wire

// ### hw/spcs_sticky_bit.v
/*
 * One sticky flag: set by a hardware event, cleared by a request.
 * Assumes set and clear come from logic on mclk; set wins over clear.
 */
`timescale 1ns/1ps
`default_nettype none

module spcs_sticky_bit (
    input  wire mclk,
    input  wire reset,
    input  wire ce,
    input  wire set,
    input  wire clr,
    output reg  flag_q
);

    // ------------------------------------------------------------------
    // flag storage
    // ------------------------------------------------------------------
    // an event in the clear cycle must not be lost, so set is tested first
    always @(posedge mclk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (ce) begin
            if (set) begin
                flag_q <= 1'b1;
            end else if (clr) begin
                flag_q <= 1'b0;
            end
        end
    end

endmodule // spcs_sticky_bit

`default_nettype wire

// ### inc/spcs_regs.vh
/*
 * Constants for the port command/status register pair: byte offsets,
 * field positions, write masks, reset values and the event layout.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef SPCS_REGS_VH
`define SPCS_REGS_VH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define SPCS_ADDR_W          8
`define SPCS_DATA_W          32
`define SPCS_HALF_W          16
`define SPCS_ZERO32          32'h00000000
`define SPCS_ZERO16          16'h0000

// ----------------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------------
`define SPCS_OFF_CMD_STS     8'h04
`define SPCS_OFF_INT_STS     8'h40
`define SPCS_OFF_INT_MASK    8'h44

// address decode results
`define SPCS_SEL_W           2
`define SPCS_SEL_NONE        2'h0
`define SPCS_SEL_CMD_STS     2'h1
`define SPCS_SEL_INT_STS     2'h2
`define SPCS_SEL_INT_MASK    2'h3

// ----------------------------------------------------------------------
// command half, bits 15:0 of the word
// ----------------------------------------------------------------------
`define SPCS_CMD_IO_EN       0
`define SPCS_CMD_MEM_EN      1
`define SPCS_CMD_BM_EN       2
`define SPCS_CMD_PAR_RESP    6
`define SPCS_CMD_ERR_RPT     8
`define SPCS_CMD_INT_DIS     10
`define SPCS_CMD_WMASK       16'h0547
`define SPCS_CMD_RESET       16'h0000

// ----------------------------------------------------------------------
// status half, bit positions inside the upper 16 bits
// ----------------------------------------------------------------------
`define SPCS_STS_INT_PEND    3
`define SPCS_STS_CAP_LIST    4
`define SPCS_STS_MDPE        8
`define SPCS_STS_STA         11
`define SPCS_STS_RTA         12
`define SPCS_STS_RMA         13
`define SPCS_STS_SSE         14
`define SPCS_STS_DPE         15
`define SPCS_STS_CAP_VAL     1'h1
`define SPCS_STS_PEND_VAL    1'h0

// ----------------------------------------------------------------------
// event vector: one sticky bit per status event
// ----------------------------------------------------------------------
`define SPCS_EV_N            6
`define SPCS_EV_MDPE         0
`define SPCS_EV_STA          1
`define SPCS_EV_RTA          2
`define SPCS_EV_RMA          3
`define SPCS_EV_SSE          4
`define SPCS_EV_DPE          5
// events whose status bit is write-one-to-clear: mdpe, sse, dpe
`define SPCS_EV_W1C          6'h31
`define SPCS_EV_RESET        6'h00
`define SPCS_EV_ZERO         6'h00

`endif

// ### testbench/spcs_far_model.sv
/* far side: upstream partner and port logic raising one-cycle requests
   and completion events at random while run is high.
   assumes one mclk domain; all pulses change just after an edge. */
`timescale 1ns/1ps
`default_nettype none
module spcs_far_model (
    input  wire logic        mclk,
    input  wire logic        run,
    output var  logic [12:0] traffic
);
    integer seed = 92;
    integer phase = 0;
    integer r;
    // ----------
    // traffic source
    // ----------
    // busy and sparse stretches alternate, so prompt and slow peers both occur
    always @(posedge mclk) begin
        phase = (phase + 1) % 64;
        r = $random(seed) & $random(seed);
        if (phase >= 32)
            r = r & $random(seed);
        traffic <= run ? r[12:0] : 13'h0000;
    end
endmodule // spcs_far_model
`default_nettype wire

// ### testbench/spcs_port_regs_asserts.sv
/* checker: port timing of the command/status register pair.
   assumes a bind onto spcs_port_regs, all on one mclk domain. */
`timescale 1ns/1ps
`default_nettype none
module spcs_port_regs_chk (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic        io_req,
    input wire logic        mem_req,
    input wire logic        io_accept_q,
    input wire logic        io_ignore_q,
    input wire logic        mem_accept_q,
    input wire logic        mem_ignore_q,
    input wire logic        up_req,
    input wire logic        up_req_posted,
    input wire logic        up_forward_q,
    input wire logic        up_reject_ur_q,
    input wire logic        up_cpl_ur_q,
    input wire logic        own_req,
    input wire logic        own_req_go_q,
    input wire logic        parity_err,
    input wire logic        parity_action_q,
    input wire logic        err_msg_req,
    input wire logic        system_error_report_line_q,
    input wire logic        intx_own_req,
    input wire logic        intx_fwd_in,
    input wire logic        intx_own_q,
    input wire logic        intx_fwd_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ----------
    // gating of primary and upstream traffic
    // ----------
    property p_io;
        ce |=> (io_accept_q ^ io_ignore_q) == $past(io_req);
    endproperty
    a_io: assert property (p_io) else $error("io answer wrong");
    property p_mem;
        ce && mem_req |=> mem_accept_q ^ mem_ignore_q;
    endproperty
    a_mem: assert property (p_mem) else $error("mem answer wrong");
    property p_up;
        ce && up_req |=> up_forward_q ^ up_reject_ur_q;
    endproperty
    a_up: assert property (p_up) else $error("upstream answer wrong");
    // only non-posted rejects owe a completion
    property p_cpl;
        ce && up_req |=> up_cpl_ur_q == (up_reject_ur_q && !$past(up_req_posted));
    endproperty
    a_cpl: assert property (p_cpl) else $error("ur completion wrong");
    // own requests and forwarding share one enable
    property p_own;
        ce && up_req && own_req |=> own_req_go_q == up_forward_q;
    endproperty
    a_own: assert property (p_own) else $error("master enable split");
    property p_par;
        $past(ce) && parity_action_q |-> $past(parity_err);
    endproperty
    a_par: assert property (p_par) else $error("parity action uncaused");
    property p_err;
        $past(ce) && system_error_report_line_q |-> $past(err_msg_req);
    endproperty
    a_err: assert property (p_err) else $error("error report uncaused");
    property p_intx;
        ce |=> intx_fwd_q == $past(intx_fwd_in) && (!intx_own_q || $past(intx_own_req));
    endproperty
    a_intx: assert property (p_intx) else $error("intx path wrong");
    // ----------
    // fixed bits of the command/status word
    // ----------
    property p_fixed;
        ce && reg_rd && reg_addr == 8'h04 |=> reg_rdata_q[20]
            && (reg_rdata_q & 32'h06EF_FAB8) == 32'h0000_0000;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
endmodule // spcs_port_regs_chk

bind spcs_port_regs spcs_port_regs_chk u_chk (.*);
`default_nettype wire

// ### testbench/testbench.sv
/* testbench: cycle model of the command/status pair compared with the
   design on every edge, with bus traffic and random port events.
   assumes spcs_port_regs, its checker and spcs_far_model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        run = 1'b0;
    logic        ce = 1'b1;
    logic        armed = 1'b0;
    logic [44:0] exp_q = 45'h0;
    logic [15:0] cmd;
    logic [5:0]  sts, ist, msk, ev;
    wire  [12:0] t;
    wire  [12:0] q;
    wire  [31:0] rdata;
    integer      failures = 0;
    integer      checks_done = 0;
    integer      cyc = 0;
    integer      seed = 92;
    integer      i, r;

    always #50 mclk = ~mclk;

    spcs_port_regs u_dut (
        .mclk(mclk), .reset(reset), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata),
        .io_req(t[0]), .mem_req(t[1]),
        .io_accept_q(q[0]), .io_ignore_q(q[1]),
        .mem_accept_q(q[2]), .mem_ignore_q(q[3]),
        .up_req(t[2]), .up_req_posted(t[3]), .up_forward_q(q[4]),
        .up_reject_ur_q(q[5]), .up_cpl_ur_q(q[6]),
        .own_req(t[4]), .own_req_go_q(q[7]),
        .parity_err(t[5]), .parity_action_q(q[8]),
        .err_msg_req(t[6]), .system_error_report_line_q(q[9]),
        .intx_own_req(t[7]), .intx_fwd_in(t[8]),
        .intx_own_q(q[10]), .intx_fwd_q(q[11]),
        .cpl_ca_sent(t[9]), .cpl_ca_rcvd(t[10]),
        .cpl_ur_rcvd(t[11]), .poisoned_rcvd(t[12]), .irq_q(q[12])
    );

    spcs_far_model u_far (.mclk(mclk), .run(run), .traffic(t));

    task automatic stop_test;
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------
    // reference model: checks last prediction, then predicts the next edge
    // ----------
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (armed && {rdata, q} !== exp_q) begin
            failures = failures + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, {rdata, q}, exp_q);
        end
        checks_done = checks_done + armed;
        armed = 1'b1;
        if (reset) begin
            cmd = 16'h0000;
            sts = 6'h00;
            ist = 6'h00;
            msk = 6'h00;
            exp_q = 45'h0;
        end else if (ce) begin
            // with ce low the design freezes, so the prediction simply stands
            // events use the enables as they stood at this edge
            ev = {t[12], t[6] & cmd[8], t[11:9], t[5] & cmd[6]};
            exp_q[12:8] = {|(ist & msk), t[8], t[7] & ~cmd[10], t[6] & cmd[8], t[5] & cmd[6]};
            exp_q[7:4] = {t[4] & cmd[2], t[2] & ~cmd[2] & ~t[3], t[2] & ~cmd[2], t[2] & cmd[2]};
            exp_q[3:0] = {t[1] & ~cmd[1], t[1] & cmd[1], t[0] & ~cmd[0], t[0] & cmd[0]};
            exp_q[44:13] = 32'h0000_0000;
            if (reg_rd && reg_addr == 8'h04)
                exp_q[44:13] = {sts[5:1], 2'b00, sts[0], 8'h10, cmd};
            if (reg_rd && reg_addr == 8'h40)
                exp_q[18:13] = ist;
            if (reg_rd && reg_addr == 8'h44)
                exp_q[18:13] = msk;
            if (reg_wr && reg_addr == 8'h04) begin
                sts = sts & ~{reg_wdata[31:30], 3'b000, reg_wdata[24]};
                cmd = reg_wdata[15:0] & 16'h0547;
            end
            if (reg_wr && reg_addr == 8'h40)
                ist = ist & ~reg_wdata[5:0];
            if (reg_wr && reg_addr == 8'h44)
                msk = reg_wdata[5:0];
            sts = sts | ev;
            ist = ist | ev;
        end
        if (cyc == 10000) begin
            failures = failures + 1;
            stop_test;
        end
    end

    // ----------
    // bus master: one strobe per cycle, changed just after the edge
    // ----------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
    endtask

    task automatic idle(input integer n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask

    // ----------
    // main sequence
    // ----------
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        // reset values, an unmapped place, then all-ones into fixed bits
        bus(1'b0, 8'h04, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        bus(1'b0, 8'h44, 32'h0);
        bus(1'b1, 8'h08, 32'hFFFF_FFFF);
        bus(1'b0, 8'h08, 32'h0);
        bus(1'b1, 8'h04, 32'hFFFF_FFFF);
        bus(1'b0, 8'h04, 32'h0);
        idle(1);
        run <= 1'b1;
        // random back-to-back accesses while the far side keeps raising events
        for (i = 0; i < 1500; i = i + 1) begin
            r = $random(seed);
            if (i == 700) begin
                reset <= 1'b1;
                idle(3);
                reset <= 1'b0;
            end else if (r[4:3] == 2'b00) begin
                // idle stretches sometimes freeze the block, events then are lost
                ce <= r[16];
                idle(r[7:5] + 1);
                ce <= 1'b1;
            end else
                bus(r[0], r[2:1] == 2'd0 ? 8'h04 : r[2:1] == 2'd1 ? 8'h40 :
                    r[2:1] == 2'd2 ? 8'h44 : r[15:8], $random(seed));
        end
        run <= 1'b0;
        bus(1'b1, 8'h40, 32'h0000_003F);
        bus(1'b0, 8'h40, 32'h0);
        idle(3);
        stop_test;
    end
endmodule // testbench
`default_nettype wire
